// ===== pkg/phmc_regs.vh
// register map, field positions and reset values of the highway config block
`ifndef PHMC_REGS_VH
`define PHMC_REGS_VH
// register addresses, demultiplexed and multiplexed form
`define PHMC_DMX_HIGHWAY_MODE 8'h10
`define PHMC_MUX_HIGHWAY_MODE 8'h20
`define PHMC_DMX_FRAME_LENGTH 8'h11
`define PHMC_MUX_FRAME_LENGTH 8'h22
`define PHMC_DMX_CLOCK_SHIFT 8'h14
`define PHMC_MUX_CLOCK_SHIFT 8'h28
`define PHMC_DMX_STATUS 8'h1F
`define PHMC_MUX_STATUS 8'h3E
`define PHMC_DMX_GLOBAL_MODE 8'h3F
`define PHMC_MUX_GLOBAL_MODE 8'h7E
// reset values
`define PHMC_RST_HIGHWAY_MODE 8'h00
`define PHMC_RST_FRAME_LENGTH 8'hFF
`define PHMC_RST_CLOCK_SHIFT 8'h00
`define PHMC_RST_GLOBAL_LOW 2'h3
// highway mode register fields
`define PHMC_HM_LAYOUT_HI 7
`define PHMC_HM_LAYOUT_LO 6
`define PHMC_HM_RATE 5
`define PHMC_HM_SYNC 4
`define PHMC_HM_AIS_HI 3
`define PHMC_HM_AIS_LO 2
`define PHMC_HM_CMP_UP 1
`define PHMC_HM_CMP_LO 0
// clock shift register fields
`define PHMC_CS_DOUBLE_RATE_SHIFT 7
`define PHMC_CS_DRE 4
`define PHMC_CS_OUTPUT_EXTRA_DELAY 3
`define PHMC_CS_URE 0
// global mode register fields
`define PHMC_GM_SPECIAL 1
`define PHMC_GM_DEMUX 0
// port layout codes
`define PHMC_LAYOUT_QUAD 2'h0
`define PHMC_LAYOUT_DUAL 2'h1
`define PHMC_LAYOUT_SINGLE 2'h2
`define PHMC_LAYOUT_DUAL_B 2'h3
// data rate stepping in kbit/s per layout
`define PHMC_STEP_QUAD 11'h100
`define PHMC_STEP_DUAL 11'h200
`define PHMC_STEP_SINGLE 11'h400
`endif

// ===== rtl/phmc_sync3.v
// three-stage input synchroniser with agreement filter
module phmc_sync3
(
   input wire i_clk,
   input wire i_rst_b,
   input wire i_din,
   output reg o_level
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   // only s2 reads s1; level moves once s2 and s3 agree
   always @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         o_level <= 1'b0;
      end
      else
      begin
         s1_q <= i_din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            o_level <= s3_q;
      end
   end
endmodule

// ===== rtl/phmc_top.v
// highway mode configuration: registers, sync, pin mapping, frame check
// Functional notes
// - decode layout field into port count and rate stepping
// - rate bit 0 bit per clock, 1 bit per two clocks when special bit is 1
// - frame starts on rising frame sync sampled by data clock
// - sync bit 0 samples on falling edge, start at next rise
// - sync bit 1 samples on rising edge, start at same edge
// - quad layout maps pins straight; dual layouts select rx by alt bits
// - dual tristates second tx; dual_b mirrors; single uses upper select
// - upper compare enable compares rx of ports 2 and 3
// - lower compare enable compares rx of ports 0 and 1
// - comparison in every layout; switch-over only outside quad layout
// - frame length field meaning depends on the layout
// - frame length checks sync period; field resets to all ones
// - special bit 0 allows 2.048 Mbit/s with 2.048 MHz clock
// - special mode shifts on rising clock edges only; both edges otherwise
// - address option 0 accepts demux addresses in mux bus mode
// - global mode reads revision in upper nibble, bits 3:2 high
// - downstream edge bit picks rising or falling sample edge
// - upstream edge bit picks rising or falling transmit edge
// - each shift option adds one clock of output delay in special mode, half a clock otherwise
`include "phmc_regs.vh"
module phmc_top
#(
   parameter [3:0] REVISION = 4'h5 // arbitrary neutral value
)
(
   input wire i_clk,
   input wire i_rst_b,
   input wire i_mux_bus,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata,
   output reg o_rdata_valid,
   input wire i_data_clock,
   input wire i_frame_sync,
   input wire [3:0] i_rx_pin,
   input wire [3:0] i_tx_data,
   input wire [3:0] i_tx_valid,
   output reg [3:0] o_tx_pin,
   output reg [3:0] o_tx_oe_b,
   output reg [3:0] o_tristate_ctrl,
   output reg [3:0] o_rx_data,
   output reg o_rx_strobe,
   output reg o_frame_start,
   output reg o_frame_err,
   output reg [1:0] o_cmp_mismatch,
   output reg [2:0] o_port_count,
   output reg [10:0] o_rate_step
);
   reg [7:0] highway_mode_q;
   reg [7:0] frame_length_q;
   reg [7:0] clock_shift_q;
   reg [1:0] global_low_q;
   reg [2:0] status_q;
   reg pdc_prev_q;
   reg phase_q;
   reg pfs_smp_q;
   reg start_pend_q;
   reg [10:0] bit_cnt_q;
   reg armed_q;
   reg [3:0] rx_dly_q;
   reg [3:0] tx_st1_q;
   reg [3:0] tx_st2_q;
   wire pdc_lvl;
   wire pfs_lvl;
   wire [3:0] rx_lvl;
   wire [1:0] layout = highway_mode_q[`PHMC_HM_LAYOUT_HI:`PHMC_HM_LAYOUT_LO];
   wire [1:0] alt_input_sel =
      highway_mode_q[`PHMC_HM_AIS_HI:`PHMC_HM_AIS_LO];
   wire clock_rate_sel = highway_mode_q[`PHMC_HM_RATE];
   wire sync_edge_sel = highway_mode_q[`PHMC_HM_SYNC];
   wire compare_upper_en = highway_mode_q[`PHMC_HM_CMP_UP];
   wire compare_lower_en = highway_mode_q[`PHMC_HM_CMP_LO];
   wire special_rate_mode = global_low_q[`PHMC_GM_SPECIAL];
   wire demux_addr_option = global_low_q[`PHMC_GM_DEMUX];
   wire down_sample_edge = clock_shift_q[`PHMC_CS_DRE];
   wire up_transmit_edge = clock_shift_q[`PHMC_CS_URE];
   wire double_rate_shift = clock_shift_q[`PHMC_CS_DOUBLE_RATE_SHIFT];
   wire output_extra_delay = clock_shift_q[`PHMC_CS_OUTPUT_EXTRA_DELAY];

   // pin inputs from the highway side pass the filtered synchroniser
   phmc_sync3 u_sync_pdc
   (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_din(i_data_clock),
      .o_level(pdc_lvl)
   );

   phmc_sync3 u_sync_pfs
   (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_din(i_frame_sync),
      .o_level(pfs_lvl)
   );

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_rx
         phmc_sync3 u_sync_rx
         (
            .i_clk(i_clk),
            .i_rst_b(i_rst_b),
            .i_din(i_rx_pin[g]),
            .o_level(rx_lvl[g])
         );
      end
   endgenerate

   // address decode; demux addresses also valid in mux mode when option 0
   wire dmx_ok = ~i_mux_bus | ~demux_addr_option;
   wire hit_hm = (dmx_ok && i_addr == `PHMC_DMX_HIGHWAY_MODE) ||
      (i_mux_bus && i_addr == `PHMC_MUX_HIGHWAY_MODE);
   wire hit_fl = (dmx_ok && i_addr == `PHMC_DMX_FRAME_LENGTH) ||
      (i_mux_bus && i_addr == `PHMC_MUX_FRAME_LENGTH);
   wire hit_cs = (dmx_ok && i_addr == `PHMC_DMX_CLOCK_SHIFT) ||
      (i_mux_bus && i_addr == `PHMC_MUX_CLOCK_SHIFT);
   wire hit_st = (dmx_ok && i_addr == `PHMC_DMX_STATUS) ||
      (i_mux_bus && i_addr == `PHMC_MUX_STATUS);
   wire hit_gm = (dmx_ok && i_addr == `PHMC_DMX_GLOBAL_MODE) ||
      (i_mux_bus && i_addr == `PHMC_MUX_GLOBAL_MODE);

   // edges of the synchronised data clock
   wire pdc_rise = pdc_lvl & ~pdc_prev_q;
   wire pdc_fall = ~pdc_lvl & pdc_prev_q;
   // double clock rate takes every second rise in special mode only; otherwise 1:1
   wire dbl = clock_rate_sel & special_rate_mode;
   wire bit_en = ~dbl | phase_q;
   // shift stages step per clock in special mode, or per half clock otherwise
   wire shift_tick = special_rate_mode ? pdc_rise :
      (pdc_rise | pdc_fall);
   wire smp_edge = sync_edge_sel ? pdc_rise : pdc_fall;
   wire pfs_now = pfs_smp_q;
   // compare with the sample of the previous edge, so a long high is one rise
   wire pfs_new_rise = smp_edge & pfs_lvl & ~pfs_now;
   // start on this rise (sync 1) or the next rise after a fall sample
   wire frame_start = pdc_rise &
      ((sync_edge_sel & pfs_new_rise) |
      (~sync_edge_sel & start_pend_q));
   wire bit_tick = pdc_rise & (bit_en | frame_start);
   wire down_tick = (down_sample_edge ? pdc_rise : pdc_fall) &
      bit_en;
   wire up_tick = (up_transmit_edge ? pdc_rise : pdc_fall) &
      bit_en;

   // expected bits per frame from the length field by layout
   reg [10:0] exp_bits;
   always @*
   begin
      case (layout)
         `PHMC_LAYOUT_QUAD:
            exp_bits = {3'h0, frame_length_q} + 11'h001;
         `PHMC_LAYOUT_SINGLE:
            exp_bits = {1'b0, frame_length_q, 2'h0} + 11'h004;
         default:
            exp_bits = {2'h0, frame_length_q, 1'b0} + 11'h002;
      endcase
   end

   // receive path: optional one-step delay, then logical mapping
   wire [3:0] rx_sel = double_rate_shift ? rx_dly_q : rx_lvl;
   reg [3:0] rx_log;
   always @*
   begin
      case (layout)
         `PHMC_LAYOUT_QUAD:
            rx_log = rx_sel;
         `PHMC_LAYOUT_SINGLE:
            rx_log = {3'h0, alt_input_sel[1] ? rx_sel[2] : rx_sel[3]};
         default:
            rx_log = {2'h0, alt_input_sel[1] ? rx_sel[2] : rx_sel[3],
               alt_input_sel[0] ? rx_sel[0] : rx_sel[1]};
      endcase
   end

   // bit by bit comparison of redundant pairs, in every layout
   wire miss_lo = down_tick & compare_lower_en &
      (rx_sel[0] ^ rx_sel[1]);
   wire miss_up = down_tick & compare_upper_en &
      (rx_sel[2] ^ rx_sel[3]);
   wire period_bad = frame_start & armed_q &
      (bit_cnt_q != exp_bits);

   // transmit path: zero, one or two delay stages
   wire [3:0] tx_sel = (double_rate_shift & output_extra_delay) ?
      tx_st2_q : ((double_rate_shift | output_extra_delay) ?
      tx_st1_q : i_tx_data);

   // physical transmit pins, enables and tristate controls
   reg [3:0] tx_phy;
   reg [3:0] oe_b_phy;
   reg [3:0] tsc_phy;
   always @*
   begin
      case (layout)
         `PHMC_LAYOUT_QUAD:
         begin
            tx_phy = tx_sel;
            oe_b_phy = 4'h0;
            tsc_phy = i_tx_valid;
         end
         `PHMC_LAYOUT_DUAL:
         begin
            tx_phy = {1'b0, tx_sel[1], 1'b0, tx_sel[0]};
            oe_b_phy = 4'hA;
            tsc_phy = {alt_input_sel[1], i_tx_valid[1],
               alt_input_sel[0], i_tx_valid[0]};
         end
         `PHMC_LAYOUT_SINGLE:
         begin
            // pin 2 is undefined here; kept off the wire
            tx_phy = {3'h0, tx_sel[0]};
            oe_b_phy = 4'hE;
            tsc_phy = {alt_input_sel[1], 1'b0, alt_input_sel[0],
               i_tx_valid[0]};
         end
         default:
         begin
            tx_phy = {tx_sel[1], tx_sel[1], tx_sel[0], tx_sel[0]};
            oe_b_phy = 4'h0;
            tsc_phy = {i_tx_valid[1], i_tx_valid[1], i_tx_valid[0],
               i_tx_valid[0]};
         end
      endcase
   end

   // register file writes
   always @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         highway_mode_q <= `PHMC_RST_HIGHWAY_MODE;
         frame_length_q <= `PHMC_RST_FRAME_LENGTH;
         clock_shift_q <= `PHMC_RST_CLOCK_SHIFT;
         global_low_q <= `PHMC_RST_GLOBAL_LOW;
      end
      else if (i_wr)
      begin
         if (hit_hm)
            highway_mode_q <= i_wdata;
         else if (hit_fl)
            frame_length_q <= i_wdata;
         else if (hit_cs)
            clock_shift_q <= i_wdata;
         else if (hit_gm)
            global_low_q <= i_wdata[1:0];
      end
   end

   // read data is registered; unmapped addresses return zero
   always @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_rdata <= 8'h00;
         o_rdata_valid <= 1'b0;
      end
      else
      begin
         o_rdata_valid <= i_rd;
         if (i_rd)
         begin
            if (hit_hm)
               o_rdata <= highway_mode_q;
            else if (hit_fl)
               o_rdata <= frame_length_q;
            else if (hit_cs)
               o_rdata <= clock_shift_q;
            else if (hit_st)
               o_rdata <= {5'h00, status_q};
            else if (hit_gm)
               o_rdata <= {REVISION, 2'h3, global_low_q};
            else
               o_rdata <= 8'h00;
         end
      end
   end

   // sticky status, cleared by read; a new event wins over the clear
   always @(posedge i_clk)
   begin
      if (!i_rst_b)
         status_q <= 3'h0;
      else
         status_q <= ((i_rd & hit_st) ? 3'h0 : status_q) |
            {miss_up, miss_lo, period_bad};
   end

   // frame sync sampling and internal frame start
   always @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         pdc_prev_q <= 1'b0;
         pfs_smp_q <= 1'b0;
         start_pend_q <= 1'b0;
      end
      else
      begin
         pdc_prev_q <= pdc_lvl;
         if (smp_edge)
            pfs_smp_q <= pfs_lvl;
         // a pending start waits only for the next rising edge
         if (frame_start)
            start_pend_q <= 1'b0;
         else if (~sync_edge_sel & pfs_new_rise)
            start_pend_q <= 1'b1;
      end
   end

   // bit phase and frame period counter
   always @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         phase_q <= 1'b1;
         bit_cnt_q <= 11'h000;
         armed_q <= 1'b0;
      end
      else
      begin
         // frame start forces bit alignment in double clock rate
         if (frame_start)
            phase_q <= 1'b0;
         else if (pdc_rise)
            phase_q <= ~phase_q;
         if (frame_start)
         begin
            bit_cnt_q <= 11'h001;
            armed_q <= 1'b1;
         end
         else if (bit_tick && bit_cnt_q != 11'h7FF)
            bit_cnt_q <= bit_cnt_q + 11'h001;
      end
   end

   // data delay stages on the shift clock
   always @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         rx_dly_q <= 4'h0;
         tx_st1_q <= 4'h0;
         tx_st2_q <= 4'h0;
      end
      else if (shift_tick)
      begin
         rx_dly_q <= rx_lvl;
         tx_st1_q <= i_tx_data;
         tx_st2_q <= tx_st1_q;
      end
   end

   // receive outputs and status outputs
   always @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_rx_data <= 4'h0;
         o_rx_strobe <= 1'b0;
         o_frame_start <= 1'b0;
         o_frame_err <= 1'b0;
         o_cmp_mismatch <= 2'h0;
      end
      else
      begin
         o_rx_strobe <= down_tick;
         if (down_tick)
            o_rx_data <= rx_log;
         o_frame_start <= frame_start;
         o_frame_err <= status_q[0] | period_bad;
         o_cmp_mismatch <= status_q[2:1] | {miss_up, miss_lo};
      end
   end

   // transmit pins change on the upstream edge; controls follow config
   always @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_tx_pin <= 4'h0;
         o_tx_oe_b <= 4'hF;
         o_tristate_ctrl <= 4'h0;
      end
      else
      begin
         if (up_tick)
            o_tx_pin <= tx_phy;
         o_tx_oe_b <= oe_b_phy;
         o_tristate_ctrl <= tsc_phy;
      end
   end

   // layout decode for the switching logic
   always @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_port_count <= 3'h4;
         o_rate_step <= `PHMC_STEP_QUAD;
      end
      else
      begin
         case (layout)
            `PHMC_LAYOUT_QUAD:
            begin
               o_port_count <= 3'h4;
               o_rate_step <= `PHMC_STEP_QUAD;
            end
            `PHMC_LAYOUT_SINGLE:
            begin
               o_port_count <= 3'h1;
               o_rate_step <= `PHMC_STEP_SINGLE;
            end
            default:
            begin
               o_port_count <= 3'h2;
               o_rate_step <= `PHMC_STEP_DUAL;
            end
         endcase
      end
   end
endmodule

// ===== bench/phmc_highway_model.sv
// highway side model: free running data clock, frame sync, receive pins
module phmc_highway_model
(
   input wire logic [7:0] i_bits,
   input wire logic [3:0] i_rx_val,
   output logic o_data_clock,
   output logic o_frame_sync,
   output logic [3:0] o_rx_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   int bit_n = 0;
   // launch a quarter period after the fall so both sampling edges have margin
   initial
   begin
      o_data_clock = 1'b0;
      o_frame_sync = 1'b0;
      o_rx_pin = 4'h0;
      forever
      begin
         #31.5 o_data_clock = 1'b1;
         #62.5 o_data_clock = 1'b0;
         #31;
         bit_n = (bit_n + 1 >= i_bits) ? 0 : bit_n + 1;
         o_frame_sync = (bit_n == 0);
         o_rx_pin = i_rx_val;
      end
   end
endmodule

// ===== bench/phmc_checker.sv
// concurrent checks on the highway mode configuration block ports
module phmc_checker
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_data_clock,
   input wire logic [3:0] o_tx_oe_b,
   input wire logic [3:0] o_tristate_ctrl,
   input wire logic o_frame_start,
   input wire logic o_frame_err,
   input wire logic [1:0] o_cmp_mismatch,
   input wire logic [2:0] o_port_count,
   input wire logic [10:0] o_rate_step
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mode_q;
   logic [3:0] steady_q;
   logic [3:0] age_q;
   logic pin_q;
   logic [2:0] exp_cnt;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   // port count expected from the shadowed layout field
   assign exp_cnt = (mode_q[7:6] == 2'h0) ? 3'h4 :
      (mode_q[7:6] == 2'h2) ? 3'h1 : 3'h2;
   // shadow of mode writes; settle count covers sync lag plus a shift tick
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         mode_q <= 8'h00;
         steady_q <= 4'h0;
         age_q <= 4'hF;
         pin_q <= 1'b0;
      end
      else
      begin
         pin_q <= i_data_clock;
         if (i_wr && i_addr == 8'h10)
            mode_q <= i_wdata;
         if (i_wr && i_addr == 8'h10)
            steady_q <= 4'h0;
         else if (steady_q != 4'hF)
            steady_q <= steady_q + 4'h1;
         if (i_data_clock && !pin_q)
            age_q <= 4'h0;
         else if (age_q != 4'hF)
            age_q <= age_q + 4'h1;
      end
   end
   sequence s_settled;
      steady_q == 4'hF;
   endsequence
   sequence s_recent_read;
      $past(i_rd) || $past(i_rd, 2) || $past(i_rd, 3);
   endsequence
   a_layout_count: assert property (s_settled |->
      o_port_count == exp_cnt) else $error("bad port count");
   a_rate_step: assert property (o_rate_step == {o_port_count == 3'h1,
      o_port_count == 3'h2, o_port_count == 3'h4, 8'h00}) else $error("step");
   a_start_after_rise: assert property (o_frame_start |->
      age_q <= 4'hA) else $error("frame start without clock rise");
   a_start_pulse: assert property (o_frame_start |=>
      !o_frame_start) else $error("frame start too long");
   a_quad_drive: assert property (s_settled ##0 mode_q[7:6] == 2'h0
      |-> o_tx_oe_b == 4'h0) else $error("quad pins not driven");
   a_dual_tristate: assert property (s_settled ##0 mode_q[7:6] == 2'h1
      |-> o_tx_oe_b[1] && o_tx_oe_b[3] && o_tristate_ctrl[1] == mode_q[2]
      && o_tristate_ctrl[3] == mode_q[3]) else $error("dual pins wrong");
   a_lower_cmp_off: assert property (s_settled ##0 !mode_q[0] |->
      !$rose(o_cmp_mismatch[0])) else $error("lower compare while off");
   a_upper_cmp_off: assert property (s_settled ##0 !mode_q[1] |->
      !$rose(o_cmp_mismatch[1])) else $error("upper compare while off");
   a_mismatch_clear: assert property ($fell(o_cmp_mismatch[0]) ||
      $fell(o_cmp_mismatch[1]) |-> s_recent_read) else $error("flag lost");
   a_period_clear: assert property ($fell(o_frame_err) |->
      s_recent_read) else $error("period flag lost");
endmodule
bind phmc_top phmc_checker u_phmc_checker
(
   .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wr(i_wr), .i_rd(i_rd),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_data_clock(i_data_clock),
   .o_tx_oe_b(o_tx_oe_b), .o_tristate_ctrl(o_tristate_ctrl),
   .o_frame_start(o_frame_start), .o_frame_err(o_frame_err),
   .o_cmp_mismatch(o_cmp_mismatch), .o_port_count(o_port_count),
   .o_rate_step(o_rate_step)
);

// ===== bench/testbench.sv
// self-checking bench of the highway mode configuration block
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst_b, mux, wr_s, rd_s, dclk, fsync, rvalid, rxs, fst, ferr;
   logic [7:0] addr, wdata, rdata, bits;
   logic [3:0] txd, txv, rxv, rxp, txp, oe_b, tsc, rxd;
   logic [1:0] cmpm;
   logic [2:0] pcnt;
   logic [10:0] rstep;
   int mismatches = 0;
   int n_compared = 0;
   // revision value 4'hA is arbitrary
   phmc_top #(.REVISION(4'hA)) u_phmc_top
   (
      .i_clk(clk), .i_rst_b(rst_b), .i_mux_bus(mux), .i_wr(wr_s),
      .i_rd(rd_s), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
      .o_rdata_valid(rvalid), .i_data_clock(dclk), .i_frame_sync(fsync),
      .i_rx_pin(rxp), .i_tx_data(txd), .i_tx_valid(txv), .o_tx_pin(txp),
      .o_tx_oe_b(oe_b), .o_tristate_ctrl(tsc), .o_rx_data(rxd),
      .o_rx_strobe(rxs), .o_frame_start(fst), .o_frame_err(ferr),
      .o_cmp_mismatch(cmpm), .o_port_count(pcnt), .o_rate_step(rstep)
   );
   phmc_highway_model u_phmc_highway_model
   (
      .i_bits(bits), .i_rx_val(rxv), .o_data_clock(dclk),
      .o_frame_sync(fsync), .o_rx_pin(rxp)
   );
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   // the answer is registered, so it is judged just after the taking edge
   task automatic rd(input logic [7:0] a, m, e);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      cmp(rvalid, 1'b1);
      cmp(rdata & m, e);
   endtask
   task automatic t_regs;
      rd(8'h10, 8'hFF, 8'h00);
      rd(8'h11, 8'hFF, 8'hFF);
      rd(8'h3F, 8'hFF, 8'hAF);
      rd(8'h05, 8'hFF, 8'h00);
      wr(8'h11, 8'h5A);
      rd(8'h11, 8'hFF, 8'h5A);
      $display("test regs done");
   endtask
   task automatic t_mux;
      @(posedge clk);
      mux <= 1'b1;
      rd(8'h22, 8'hFF, 8'h5A);
      rd(8'h11, 8'hFF, 8'h00);
      wr(8'h20, 8'h30);
      wr(8'h28, 8'h11);
      wr(8'h7E, 8'h02);
      rd(8'h11, 8'hFF, 8'h5A);
      rd(8'h7E, 8'hFF, 8'hAE);
      wr(8'h7E, 8'h03);
      mux <= 1'b0;
      $display("test mux done");
   endtask
   // every layout plus double rate; frames of 8 clocks match, 9 do not
   task automatic t_frames;
      logic [7:0] md [5] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h20};
      logic [7:0] bn [5] = '{8'h07, 8'h03, 8'h01, 8'h03, 8'h03};
      logic [2:0] cn [5] = '{3'h4, 3'h2, 3'h1, 3'h2, 3'h4};
      logic [10:0] st [5] = '{11'h100, 11'h200, 11'h400, 11'h200, 11'h100};
      for (int i = 0; i < 5; i++)
      begin
         wr(8'h10, md[i]);
         wr(8'h11, bn[i]);
         bits <= 8'h08;
         cyc(400);
         rd(8'h1F, 8'h00, 8'h00);
         cyc(300);
         rd(8'h1F, 8'h01, 8'h00);
         cmp(pcnt, cn[i]);
         cmp(rstep, st[i]);
         bits <= 8'h09;
         cyc(450);
         cmp(ferr, 1'b1);
         rd(8'h1F, 8'h01, 8'h01);
      end
      bits <= 8'h08;
      $display("test frames done");
   endtask
   // sync sampled on the fall starts one data clock later than on the rise
   task automatic t_sync;
      int lat [2];
      wr(8'h11, 8'h07);
      for (int s = 0; s < 2; s++)
      begin
         wr(8'h10, s ? 8'h10 : 8'h00);
         @(posedge fsync);
         @(posedge fsync);
         lat[s] = 0;
         while (fst !== 1'b1 && lat[s] < 60)
         begin
            #10;
            lat[s]++;
         end
      end
      cmp(lat[1] <= 14, 1'b1);
      cmp(lat[0] >= 16 && lat[0] <= 35, 1'b1);
      $display("test sync done");
   endtask
   // rx pins 0110, tx data 1010, valid 0011 seen through each mapping
   task automatic t_pins;
      logic [7:0] md [5] = '{8'h00, 8'h40, 8'h4C, 8'hC0, 8'h88};
      logic [3:0] rm [5] = '{4'hF, 4'h3, 4'h3, 4'h3, 4'h1};
      logic [3:0] re [5] = '{4'h6, 4'h1, 4'h2, 4'h1, 4'h1};
      logic [3:0] pm [5] = '{4'hF, 4'h5, 4'h5, 4'hF, 4'h1};
      logic [3:0] pe [5] = '{4'hA, 4'h4, 4'h4, 4'hC, 4'h0};
      logic [3:0] oe [5] = '{4'h0, 4'hA, 4'hA, 4'h0, 4'hE};
      logic [3:0] ts [5] = '{4'h3, 4'h5, 4'hF, 4'hF, 4'h9};
      int n;
      for (int i = 0; i < 5; i++)
      begin
         wr(8'h10, md[i]);
         cyc(40);
         cmp(rxd & rm[i], re[i]);
         cmp(txp & pm[i], pe[i]);
         cmp(oe_b, oe[i]);
         cmp(tsc, ts[i]);
      end
      // one receive strobe per data clock period of 125 ns
      repeat (2) @(posedge clk iff rxs);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (!rxs);
      cmp(n >= 12 && n <= 13, 1'b1);
      $display("test pins done");
   endtask
   task automatic t_cmp;
      wr(8'h10, 8'h01);
      cyc(40);
      cmp(cmpm, 2'b01);
      wr(8'h10, 8'h42);
      cyc(20);
      rd(8'h1F, 8'h00, 8'h00);
      cyc(40);
      cmp(cmpm, 2'b10);
      $display("test compare done");
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // main sequence
   initial
   begin
      rst_b = 1'b0;
      mux = 1'b0;
      wr_s = 1'b0;
      rd_s = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      txd = 4'hA;
      txv = 4'h3;
      rxv = 4'h6;
      bits = 8'h08;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_regs;
      t_mux;
      t_frames;
      t_sync;
      t_pins;
      t_cmp;
      stop_test;
   end
   // watchdog well beyond the roughly 66 us the tests need
   initial
   begin
      #300us;
      mismatches++;
      stop_test;
   end
endmodule
